// ==== shared/e1am_pkg.sv ====
// Package for the E1 receive alarm monitor: register map, field layout,
// detection thresholds and the carrier structs shared by the design files.
// Assumes a single receive clock at the rate given by e1am_clk_hz.
package e1am_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register map. The low byte is the register, the upper nibble the link.
  localparam logic [7:0] E1AM_OFS_ALARM_STATE = 8'hB9;
  localparam logic [7:0] E1AM_OFS_IRQ_ENABLE = 8'hBA;
  localparam logic [7:0] E1AM_OFS_CHANGE_FLAGS = 8'hBB;
  localparam int E1AM_ADDR_W = 12;
  localparam int E1AM_LINK_LSB = 8;
  localparam int E1AM_NUM_LINKS = 4;
  localparam logic [7:0] E1AM_RESET_BYTE = 8'h00;
  // Only bits 5..0 exist; bits 7 and 6 are reserved and read as zero.
  localparam logic [7:0] E1AM_LIVE_MASK = 8'h3F;

  //////////////////////////////////////////////////////////////////////////
  // Detection thresholds.
  localparam logic [4:0] E1AM_TS16_RUN = 5'h10;
  localparam logic [3:0] E1AM_TS16_PERIOD_LAST = 4'hF;
  localparam logic [4:0] E1AM_TS16_AIS_ZEROS = 5'h04;
  localparam logic [4:0] E1AM_TS16_AIS_PERIODS = 5'h02;
  localparam logic [4:0] E1AM_Y_ONES = 5'h03;
  localparam logic [4:0] E1AM_A_ONES = 5'h04;
  localparam logic [8:0] E1AM_WIN_LAST = 9'h1FF;
  localparam logic [4:0] E1AM_WIN_ZEROS = 5'h03;

  //////////////////////////////////////////////////////////////////////////
  // Frame-loss persistence time.
  localparam longint E1AM_CLK_HZ = 200_000_000;
  localparam longint E1AM_PERSIST_MS = 100;
  localparam longint E1AM_MS_PER_S = 1000;
  localparam longint E1AM_PERSIST_CYCLES =
    E1AM_CLK_HZ / E1AM_MS_PER_S * E1AM_PERSIST_MS;
  localparam int E1AM_PERSIST_W = 25;

  //////////////////////////////////////////////////////////////////////////
  // Carriers.
  // Alarm byte: same layout in status, enable and change-flag registers.
  typedef struct packed {
    logic [1:0] reserved;
    logic slot16_loss;
    logic slot16_all_ones;
    logic remote_multiframe;
    logic all_ones;
    logic remote_alarm;
    logic frame_loss;
  } e1am_alarm_t;

  // Per-link indications from the framer, all on the receive clock.
  typedef struct packed {
    logic bit_valid;
    logic bit_data;
    logic frame_sync;
    logic cas_mf_sync;
    logic ts16_valid;
    logic [7:0] ts16_octet;
    logic a_valid;
    logic a_bit;
    logic y_valid;
    logic y_bit;
  } e1am_rx_t;

  // Per-link criterion selects.
  typedef struct packed {
    logic all_ones_criterion_sel;
    logic remote_criterion_sel;
  } e1am_crit_t;

endpackage : e1am_pkg

// ==== rtl/e1am_persist.sv ====
// Persistence timer that turns the basic frame sync level into the
// frame-loss alarm state. Assumes sync_i is on clk_i already.
`timescale 1ns/1ps
module e1am_persist #(
  parameter int CNT_W = 25,
  parameter logic [CNT_W-1:0] CYCLES = 25'd20000000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic sync_i,
  output logic alarm_o
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic next_alarm;

  ////////////////////////////////////////////////////////////////////////////
  // The count runs only while the sync level equals the alarm level, so a
  // single glitch of sync restarts the whole interval.
  always_comb begin
    next_cnt = cnt;
    next_alarm = alarm_o;
    if (sync_i == alarm_o) begin
      if (cnt >= CYCLES - 1'b1) begin
        next_alarm = ~alarm_o;
        next_cnt = '0;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end else begin
      next_cnt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
      alarm_o <= 1'b0;
    end else if (ce_i) begin
      cnt <= next_cnt;
      alarm_o <= next_alarm;
    end
  end

endmodule : e1am_persist

// ==== rtl/e1am_top.sv ====
// E1 receive alarm monitor for several links: alarm detection, sticky
// change flags, interrupt enables and the byte-wide register port.
// Assumes all framer indications are produced on clk_i.
`timescale 1ns/1ps
// Function
// - TS16 loss: 16 zero octets set, 16 nonzero clear
// - TS16 all-ones: two low-zero periods set
// - Remote multiframe: three Y ones set, zero clears
// - All-ones, criterion 0: one window, out of sync
// - All-ones, criterion 1: two consecutive windows
// - Remote alarm, criterion 0: four A ones
// - Remote alarm, criterion 1: single A bit
// - Frame-loss alarm after 100ms persistence
// - Change flag sets on any state toggle
// - Writing one clears a change flag
// - Enabled set flags drive the interrupt
// - Shared bit layout, bits 7..6 reserved
// - One register set per link, link nibble
// - Remote and frame-loss flags behave alike
module e1am_top
  import e1am_pkg::*;
#(
  parameter int NUM_LINKS = E1AM_NUM_LINKS,
  parameter logic [E1AM_PERSIST_W-1:0] PERSIST_CYCLES =
    E1AM_PERSIST_W'(E1AM_PERSIST_CYCLES)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire e1am_rx_t [NUM_LINKS-1:0] rx_i,
  input wire e1am_crit_t [NUM_LINKS-1:0] crit_i,
  input wire logic [E1AM_ADDR_W-1:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic irq_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.
  function automatic logic [4:0] e1am_sat_inc(input logic [4:0] v,
                                               input logic [4:0] lim);
    return (v >= lim) ? lim : v + 5'h01;
  endfunction : e1am_sat_inc

  function automatic logic [4:0] e1am_zeros8(input logic [7:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 8; i++) begin
      n = n + {4'h0, ~v[i]};
    end
    return n;
  endfunction : e1am_zeros8

  // Per-link detector state.
  typedef struct packed {
    logic [4:0] ts16_zero_run;
    logic [4:0] ts16_live_run;
    logic [3:0] ts16_frame;
    logic [4:0] ts16_zeros;
    logic [4:0] ts16_low_periods;
    logic slot16_loss;
    logic slot16_all_ones;
    logic [4:0] y_ones;
    logic remote_multiframe;
    logic [8:0] win_bit;
    logic [4:0] win_zeros;
    logic win_prev_valid;
    logic win_prev_low;
    logic all_ones;
    logic [4:0] a_ones;
    logic remote_alarm;
  } e1am_det_t;

  e1am_det_t [NUM_LINKS-1:0] det;
  e1am_det_t [NUM_LINKS-1:0] next_det;
  logic [NUM_LINKS-1:0] frame_loss;

  ////////////////////////////////////////////////////////////////////////////
  // Frame-loss persistence, one timer per link.
  for (genvar g = 0; g < NUM_LINKS; g++) begin : g_persist
    e1am_persist #(
      .CNT_W(E1AM_PERSIST_W),
      .CYCLES(PERSIST_CYCLES)
    ) u_persist (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .sync_i(rx_i[g].frame_sync),
      .alarm_o(frame_loss[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm detection.
  always_comb begin
    logic [4:0] z;
    logic [4:0] wz;
    logic low;
    z = 5'h00;
    wz = 5'h00;
    low = 1'b0;
    next_det = det;
    for (int l = 0; l < NUM_LINKS; l++) begin
      // TS16 checks only make sense inside basic frame alignment.
      if (!rx_i[l].frame_sync) begin
        next_det[l].ts16_zero_run = 5'h00;
        next_det[l].ts16_live_run = 5'h00;
        next_det[l].ts16_frame = 4'h0;
        next_det[l].ts16_zeros = 5'h00;
        next_det[l].ts16_low_periods = 5'h00;
      end else if (rx_i[l].ts16_valid) begin
        if (rx_i[l].ts16_octet == 8'h00) begin
          next_det[l].ts16_zero_run =
            e1am_sat_inc(det[l].ts16_zero_run, E1AM_TS16_RUN);
          next_det[l].ts16_live_run = 5'h00;
          if (next_det[l].ts16_zero_run == E1AM_TS16_RUN) begin
            next_det[l].slot16_loss = 1'b1;
          end
        end else begin
          next_det[l].ts16_live_run =
            e1am_sat_inc(det[l].ts16_live_run, E1AM_TS16_RUN);
          next_det[l].ts16_zero_run = 5'h00;
          if (next_det[l].ts16_live_run == E1AM_TS16_RUN) begin
            next_det[l].slot16_loss = 1'b0;
          end
        end
        // Zero count saturates at the threshold; only below/at matters.
        z = det[l].ts16_zeros + e1am_zeros8(rx_i[l].ts16_octet);
        if (z > E1AM_TS16_AIS_ZEROS) begin
          z = E1AM_TS16_AIS_ZEROS;
        end
        if (det[l].ts16_frame == E1AM_TS16_PERIOD_LAST) begin
          next_det[l].ts16_frame = 4'h0;
          next_det[l].ts16_zeros = 5'h00;
          if (z < E1AM_TS16_AIS_ZEROS) begin
            next_det[l].ts16_low_periods =
              e1am_sat_inc(det[l].ts16_low_periods, E1AM_TS16_AIS_PERIODS);
            if (next_det[l].ts16_low_periods == E1AM_TS16_AIS_PERIODS) begin
              next_det[l].slot16_all_ones = 1'b1;
            end
          end else begin
            next_det[l].ts16_low_periods = 5'h00;
            next_det[l].slot16_all_ones = 1'b0;
          end
        end else begin
          next_det[l].ts16_frame = det[l].ts16_frame + 4'h1;
          next_det[l].ts16_zeros = z;
        end
      end

      // Remote multiframe alarm from the Y bit.
      if (!rx_i[l].cas_mf_sync) begin
        next_det[l].y_ones = 5'h00;
      end else if (rx_i[l].y_valid) begin
        if (rx_i[l].y_bit) begin
          next_det[l].y_ones = e1am_sat_inc(det[l].y_ones, E1AM_Y_ONES);
          if (next_det[l].y_ones == E1AM_Y_ONES) begin
            next_det[l].remote_multiframe = 1'b1;
          end
        end else begin
          next_det[l].y_ones = 5'h00;
          next_det[l].remote_multiframe = 1'b0;
        end
      end

      // All-ones detection over fixed 512-bit windows of the raw stream.
      if (rx_i[l].bit_valid) begin
        wz = det[l].win_zeros + {4'h0, ~rx_i[l].bit_data};
        if (wz > E1AM_WIN_ZEROS) begin
          wz = E1AM_WIN_ZEROS;
        end
        if (det[l].win_bit == E1AM_WIN_LAST) begin
          low = (wz < E1AM_WIN_ZEROS);
          next_det[l].win_bit = 9'h000;
          next_det[l].win_zeros = 5'h00;
          next_det[l].win_prev_valid = 1'b1;
          next_det[l].win_prev_low = low;
          if (!crit_i[l].all_ones_criterion_sel) begin
            if (low && !rx_i[l].frame_sync) begin
              next_det[l].all_ones = 1'b1;
            end else if (!low) begin
              next_det[l].all_ones = 1'b0;
            end
          end else if (det[l].win_prev_valid &&
                       det[l].win_prev_low == low) begin
            next_det[l].all_ones = low;
          end
        end else begin
          next_det[l].win_bit = det[l].win_bit + 9'h001;
          next_det[l].win_zeros = wz;
        end
      end

      // Remote alarm from the A bit, counted inside basic frame sync.
      if (!rx_i[l].frame_sync) begin
        next_det[l].a_ones = 5'h00;
      end else if (rx_i[l].a_valid) begin
        if (rx_i[l].a_bit) begin
          next_det[l].a_ones = e1am_sat_inc(det[l].a_ones, E1AM_A_ONES);
          if (crit_i[l].remote_criterion_sel) begin
            next_det[l].remote_alarm = 1'b1;
          end else if (next_det[l].a_ones == E1AM_A_ONES) begin
            next_det[l].remote_alarm = 1'b1;
          end
        end else begin
          next_det[l].a_ones = 5'h00;
          next_det[l].remote_alarm = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      det <= '0;
    end else if (ce_i) begin
      det <= next_det;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file, change flags and interrupt.
  e1am_alarm_t [NUM_LINKS-1:0] state;
  e1am_alarm_t [NUM_LINKS-1:0] prev_state;
  e1am_alarm_t [NUM_LINKS-1:0] irq_en;
  e1am_alarm_t [NUM_LINKS-1:0] flags;
  e1am_alarm_t [NUM_LINKS-1:0] next_irq_en;
  e1am_alarm_t [NUM_LINKS-1:0] next_flags;
  logic [7:0] next_rdata;
  logic next_irq_n;
  logic [3:0] sel_link;
  logic link_ok;

  assign sel_link = addr_i[E1AM_ADDR_W-1:E1AM_LINK_LSB];
  assign link_ok = (32'(sel_link) < NUM_LINKS);

  always_comb begin
    for (int l = 0; l < NUM_LINKS; l++) begin
      state[l] = e1am_alarm_t'(E1AM_RESET_BYTE);
      state[l].slot16_loss = det[l].slot16_loss;
      state[l].slot16_all_ones = det[l].slot16_all_ones;
      state[l].remote_multiframe = det[l].remote_multiframe;
      state[l].all_ones = det[l].all_ones;
      state[l].remote_alarm = det[l].remote_alarm;
      state[l].frame_loss = frame_loss[l];
    end
  end

  always_comb begin
    logic hit;
    hit = 1'b0;
    next_irq_en = irq_en;
    next_flags = flags;
    next_rdata = rdata_o;
    next_irq_n = 1'b1;
    for (int l = 0; l < NUM_LINKS; l++) begin
      hit = link_ok && (sel_link == 4'(l));
      // The clear is applied first so that a toggle in the same cycle wins.
      if (hit && wr_i && addr_i[7:0] == E1AM_OFS_CHANGE_FLAGS) begin
        next_flags[l] = flags[l] & ~wdata_i;
      end
      next_flags[l] = (next_flags[l] | (state[l] ^ prev_state[l])) &
                      E1AM_LIVE_MASK;
      if (hit && wr_i && addr_i[7:0] == E1AM_OFS_IRQ_ENABLE) begin
        next_irq_en[l] = wdata_i & E1AM_LIVE_MASK;
      end
      if ((next_flags[l] & next_irq_en[l]) != E1AM_RESET_BYTE) begin
        next_irq_n = 1'b0;
      end
    end
    if (rd_i) begin
      next_rdata = E1AM_RESET_BYTE;
      for (int l = 0; l < NUM_LINKS; l++) begin
        if (link_ok && sel_link == 4'(l)) begin
          case (addr_i[7:0])
            E1AM_OFS_ALARM_STATE: next_rdata = state[l];
            E1AM_OFS_IRQ_ENABLE: next_rdata = irq_en[l];
            E1AM_OFS_CHANGE_FLAGS: next_rdata = flags[l];
            default: next_rdata = E1AM_RESET_BYTE;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_state <= '0;
      irq_en <= '0;
      flags <= '0;
      rdata_o <= E1AM_RESET_BYTE;
      irq_n_o <= 1'b1;
    end else if (ce_i) begin
      prev_state <= state;
      irq_en <= next_irq_en;
      flags <= next_flags;
      rdata_o <= next_rdata;
      irq_n_o <= next_irq_n;
    end
  end

endmodule : e1am_top

// ==== testbench/e1am_properties.sv ====
// Port-level checker for the alarm monitor top.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ps
module e1am_properties
  import e1am_pkg::*;
#(
  parameter int NUM_LINKS = E1AM_NUM_LINKS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [E1AM_ADDR_W-1:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic irq_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic mapped;
  assign mapped = (32'(addr_i[11:8]) < NUM_LINKS) &&
    (addr_i[7:0] inside {8'hB9, 8'hBA, 8'hBB});
  ////////////////////////////////////////////////////////////
  reset_values_a: assert property (disable iff (1'b0)
    rst_i && ce_i |=> irq_n_o && rdata_o == 8'h00)
    else $error("registers not cleared by reset");
  reserved_bits_a: assert property (
    rd_i && ce_i |=> rdata_o[7:6] == 2'b00)
    else $error("reserved read bits not zero");
  unmapped_read_a: assert property (
    rd_i && ce_i && !mapped |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (
    !(rd_i && ce_i) |=> $stable(rdata_o))
    else $error("read data changed without a read");
  ce_freeze_a: assert property (
    !ce_i |=> $stable(irq_n_o))
    else $error("interrupt moved while clock enable low");
  irq_release_a: assert property (
    $rose(irq_n_o) |-> $past(wr_i && ce_i) || $past(rst_i))
    else $error("interrupt released without a write");
  irq_hold_a: assert property (
    !irq_n_o && !(wr_i && ce_i) |=> !irq_n_o)
    else $error("interrupt dropped while flags stayed");
  enable_readback_a: assert property (
    (wr_i && ce_i && mapped && addr_i[7:0] == 8'hBA) ##1
    (rd_i && ce_i && !wr_i && $stable(addr_i))
    |=> rdata_o == ($past(wdata_i, 2) & 8'h3F))
    else $error("enable register readback wrong");
endmodule : e1am_properties

bind e1am_top e1am_properties #(.NUM_LINKS(NUM_LINKS)) i_e1am_properties (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
  .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
  .irq_n_o(irq_n_o));

// ==== testbench/e1am_far_end.sv ====
// Far-end line and framer model: sync levels and extracted bits per link.
// Assumes its tasks are called from the bench on clk_i.
`timescale 1ns/1ps
module e1am_far_end
  import e1am_pkg::*;
(
  input wire logic clk_i,
  output e1am_rx_t [E1AM_NUM_LINKS-1:0] rx_o
);
  initial begin
    rx_o = '0;
    for (int l = 0; l < E1AM_NUM_LINKS; l++) begin
      rx_o[l].frame_sync = 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////
  // Kind 0 is an A bit, 1 a Y bit, else a TS16 octet.
  task automatic send(input int l, input int kind, input logic [7:0] v);
    @(posedge clk_i);
    case (kind)
      0: {rx_o[l].a_valid, rx_o[l].a_bit} <= {1'b1, v[0]};
      1: {rx_o[l].y_valid, rx_o[l].y_bit} <= {1'b1, v[0]};
      default: {rx_o[l].ts16_valid, rx_o[l].ts16_octet} <= {1'b1, v};
    endcase
    @(posedge clk_i);
    // Unqualified data is inverted so stale values never look valid.
    rx_o[l].a_valid <= 1'b0;
    rx_o[l].y_valid <= 1'b0;
    rx_o[l].ts16_valid <= 1'b0;
    rx_o[l].a_bit <= ~v[0];
    rx_o[l].y_bit <= ~v[0];
    rx_o[l].ts16_octet <= ~v;
  endtask : send
  task automatic set_sync(input int l, input logic fs, input logic mf);
    @(posedge clk_i);
    rx_o[l].frame_sync <= fs;
    rx_o[l].cas_mf_sync <= mf;
  endtask : set_sync
  // One 512-bit window whose first nz bits are zero.
  task automatic send_window(input int l, input int nz);
    for (int i = 0; i < 512; i++) begin
      @(posedge clk_i);
      rx_o[l].bit_valid <= 1'b1;
      rx_o[l].bit_data <= (i >= nz);
    end
    @(posedge clk_i);
    rx_o[l].bit_valid <= 1'b0;
    rx_o[l].bit_data <= 1'b0;
  endtask : send_window
endmodule : e1am_far_end

// ==== testbench/test_e1_receive_alarm_monitor.sv ====
// Self-checking bench for the alarm monitor, four links, short timer.
// Assumes the package and the far-end model are compiled first.
`timescale 1ns/1ps
module test_e1_receive_alarm_monitor
  import e1am_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic rd_seen = 1'b0;
  logic [11:0] addr_i = 12'h000;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  logic irq_n_o;
  logic [27:0] note;
  logic [27:0] note_q[$];
  e1am_rx_t [3:0] rx;
  e1am_crit_t [3:0] crit = '0;
  int error_cnt = 0;
  int checked = 0;
  always #2.5 clk_i = ~clk_i;
  e1am_far_end i_e1am_far_end (.clk_i(clk_i), .rx_o(rx));
  e1am_top #(.PERSIST_CYCLES(25'd20)) i_e1am_top (.clk_i(clk_i),
    .rst_i(rst_i), .ce_i(ce_i), .rx_i(rx), .crit_i(crit),
    .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
    .rdata_o(rdata_o), .irq_n_o(irq_n_o));
  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // Write, then read back in the very next cycle with the address held.
  task automatic wr_rd(input logic [11:0] a, input logic [7:0] d,
                       input logic [7:0] e);
    @(posedge clk_i);
    {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
    @(posedge clk_i);
    {wr_i, rd_i} <= {1'b0, 1'b1};
    note_q.push_back({a, e, 8'hFF});
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask : wr_rd
  task automatic rd(input logic [11:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    @(posedge clk_i);
    {addr_i, rd_i} <= {a, 1'b1};
    note_q.push_back({a, e, m});
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask : rd
  task automatic irq_chk(input logic e);
    @(negedge clk_i);
    checked++;
    if (irq_n_o !== e) begin
      error_cnt++;
      $display("FAIL irq_n_o expected %b seen %b", e, irq_n_o);
    end
  endtask : irq_chk
  task automatic end_of_test;
    if (note_q.size() != 0) begin
      error_cnt++;
      $display("FAIL read notes expected 0 seen %0d", note_q.size());
    end
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  // Read data stands one cycle after the read edge.
  always @(posedge clk_i) begin
    rd_seen <= rd_i && ce_i && !rst_i;
    if (rd_seen) begin
      note = note_q.pop_front();
      checked++;
      if ((rdata_o & note[7:0]) !== note[15:8]) begin
        error_cnt++;
        $display("FAIL rdata %h expected %h seen %h", note[27:16],
                 note[15:8], rdata_o & note[7:0]);
      end
    end
  end
  initial begin
    #100000;
    error_cnt++;
    $display("FAIL watchdog expected done seen timeout");
    end_of_test();
  end
  initial begin
    logic [7:0] v;
    void'($urandom(44664));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int l = 0; l < 4; l++) begin
      for (int r = 0; r < 3; r++) begin
        rd({l[3:0], 8'hB9 + r[7:0]}, 8'h00, 8'hFF);
      end
    end
    rd(12'h4B9, 8'h00, 8'hFF);
    rd(12'h0BC, 8'h00, 8'hFF);
    v = 8'($urandom);
    wr(12'h1BA, v);
    rd(12'h1BA, v & 8'h3F, 8'hFF);
    wr(12'h1B9, 8'hFF);
    rd(12'h1B9, 8'h00, 8'hFF);
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(12'h1BA, ~v);
    ce_i <= 1'b1;
    rd(12'h1BA, v & 8'h3F, 8'hFF);
    rd(12'h0BA, 8'h00, 8'hFF);
    v = 8'($urandom);
    wr_rd(12'h2BA, v, v & 8'h3F);
    wr(12'h0BA, 8'h02);
    repeat (3) i_e1am_far_end.send(0, 0, 8'h01);
    rd(12'h0B9, 8'h00, 8'h02);
    irq_chk(1'b1);
    i_e1am_far_end.send(0, 0, 8'h01);
    rd(12'h0B9, 8'h02, 8'h02);
    rd(12'h0BB, 8'h02, 8'h3F);
    irq_chk(1'b0);
    wr(12'h0BA, 8'h00);
    irq_chk(1'b1);
    wr(12'h0BA, 8'h02);
    irq_chk(1'b0);
    wr(12'h0BB, 8'hFD);
    rd(12'h0BB, 8'h02, 8'h02);
    wr(12'h0BB, 8'h02);
    rd(12'h0BB, 8'h00, 8'h02);
    irq_chk(1'b1);
    i_e1am_far_end.send(0, 0, 8'h00);
    rd(12'h0B9, 8'h00, 8'h02);
    rd(12'h0BB, 8'h02, 8'h02);
    wr(12'h0BB, 8'h02);
    @(posedge clk_i);
    crit[0].remote_criterion_sel <= 1'b1;
    i_e1am_far_end.send(0, 0, 8'h01);
    rd(12'h0B9, 8'h02, 8'h02);
    i_e1am_far_end.send(0, 0, 8'h00);
    rd(12'h0B9, 8'h00, 8'h02);
    wr(12'h0BB, 8'h02);
    i_e1am_far_end.set_sync(0, 1'b1, 1'b1);
    repeat (2) i_e1am_far_end.send(0, 1, 8'h01);
    rd(12'h0B9, 8'h00, 8'h08);
    i_e1am_far_end.send(0, 1, 8'h01);
    rd(12'h0B9, 8'h08, 8'h08);
    irq_chk(1'b1);
    i_e1am_far_end.send(0, 1, 8'h00);
    rd(12'h0B9, 8'h00, 8'h08);
    repeat (32) i_e1am_far_end.send(0, 2, 8'hFF);
    rd(12'h0B9, 8'h10, 8'h30);
    repeat (15) i_e1am_far_end.send(0, 2, 8'h00);
    rd(12'h0B9, 8'h10, 8'h30);
    i_e1am_far_end.send(0, 2, 8'h00);
    rd(12'h0B9, 8'h20, 8'h30);
    repeat (16) i_e1am_far_end.send(0, 2, 8'h01);
    rd(12'h0B9, 8'h00, 8'h30);
    i_e1am_far_end.set_sync(0, 1'b0, 1'b0);
    repeat (25) @(posedge clk_i);
    rd(12'h0B9, 8'h01, 8'h01);
    i_e1am_far_end.send_window(0, 0);
    rd(12'h0B9, 8'h04, 8'h04);
    i_e1am_far_end.send_window(0, 3);
    rd(12'h0B9, 8'h00, 8'h04);
    @(posedge clk_i);
    crit[0].all_ones_criterion_sel <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      i_e1am_far_end.send_window(0, (i >= 2) ? 3 : 0);
      rd(12'h0B9, (i == 0 || i == 3) ? 8'h00 : 8'h04, 8'h04);
    end
    i_e1am_far_end.set_sync(0, 1'b1, 1'b0);
    repeat (25) @(posedge clk_i);
    rd(12'h0B9, 8'h00, 8'h01);
    rd(12'h0BB, 8'h01, 8'h01);
    // A quiet window inside frame sync must not raise the alarm.
    @(posedge clk_i);
    crit[0].all_ones_criterion_sel <= 1'b0;
    i_e1am_far_end.send_window(0, 0);
    rd(12'h0B9, 8'h00, 8'h04);
    repeat (4) @(posedge clk_i);
    end_of_test();
  end
endmodule : test_e1_receive_alarm_monitor
